//--- core/vmic_dev.sv
// Purpose: Write-only two-wire target that holds the crosspoint settings.
// Assumes: link_clk oversamples the bus; core_clk serves the settings.
// Notes: Settings cross by toggle; bytes are at least nine SCL bits apart.
`timescale 1ns/1ps
module vmic_dev
  import vmic_pkg::*;
#(
  parameter int FILT = FILT_CYC
) (
  input wire logic link_clk, // Bus sampling clock.
  input wire logic core_clk, // Clock of the settings outputs.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic addr_select_lo_pin, // Strap for address bit 6.
  input wire logic addr_select_hi_pin, // Strap for address bit 7.
  vmic_if.dev bus, // Two-wire bus.
  output logic [NUM_OUT*SEL_W-1:0] route_sel_r, // Input select per output.
  output logic [NUM_OUT-1:0] amp_on_r, // Output amplifier powered.
  output logic [NUM_OUT-1:0] idle_in_r, // Amplifier fed the idle level.
  output logic [NUM_IN-1:0] clamp_mode_r, // 1 clamp, 0 bias, per input.
  output logic [NUM_OUT-1:0] gain_0db_r, // 1 is 0 dB, 0 is 6 dB.
  output logic cfg_update_r // One-cycle pulse on new settings.
);
  if (FILT < 1 || FILT > 15) begin : g_bad_filt
    $error("FILT must lie between 1 and 15");
  end

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RECV,
    ST_ACK,
    ST_SKIP
  } vmic_lst_type;

  typedef struct packed {
    logic [1:0][1:0] sy;
    logic [1:0][1:0] pin_sy;
    logic [1:0] filt;
    logic [1:0] prev;
    logic [1:0][3:0] cnt;
    vmic_lst_type st;
    logic [3:0] bitcnt;
    logic [1:0] byte_idx;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic [NUM_REGS-1:0][7:0] cfg;
    logic ack_oe;
    logic tgl;
  } vmic_lnk_type;

  typedef struct packed {
    logic [1:0] tgl_sy;
    logic tgl_p;
    logic [NUM_OUT-1:0][SEL_W-1:0] route;
    logic [NUM_OUT-1:0] amp_on;
    logic [NUM_OUT-1:0] idle;
    logic [NUM_IN-1:0] clamp;
    logic [NUM_OUT-1:0] gain;
    logic upd;
  } vmic_cor_type;

  vmic_lnk_type l_r;
  vmic_lnk_type l_nxt;
  vmic_cor_type c_r;
  vmic_cor_type c_nxt;
  logic [1:0] line_in;
  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] my_addr;
  logic addr_hit;

  // Index 0 is SCL, index 1 is SDA.
  assign line_in = {bus.sda, bus.scl};
  assign scl_f = l_r.filt[0];
  assign sda_f = l_r.filt[1];
  assign scl_rise = scl_f & ~l_r.prev[0];
  assign scl_fall = ~scl_f & l_r.prev[0];
  // A data change while the clock stays high is a bus condition.
  assign start_cond = scl_f & l_r.prev[0] & l_r.prev[1]
    & ~sda_f;
  assign stop_cond = scl_f & l_r.prev[0] & ~l_r.prev[1]
    & sda_f;
  assign my_addr = {l_r.pin_sy[1][1], l_r.pin_sy[0][1],
    ADDR_BASE[5:0]};
  assign addr_hit = (l_r.shreg[7:1] == my_addr[7:1])
    && !l_r.shreg[RW_BIT];

  // The device only ever pulls SDA low in an acknowledge slot.
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = l_r.ack_oe;

  always_comb begin
    l_nxt = l_r;
    l_nxt.sy[0] = {l_r.sy[0][0], line_in[0]};
    l_nxt.sy[1] = {l_r.sy[1][0], line_in[1]};
    l_nxt.pin_sy[0] = {l_r.pin_sy[0][0], addr_select_lo_pin};
    l_nxt.pin_sy[1] = {l_r.pin_sy[1][0], addr_select_hi_pin};
    l_nxt.prev = l_r.filt;
    // A new line level is adopted only after it held for FILT + 1 samples.
    for (int i = 0; i < 2; i++) begin
      if (l_r.sy[i][1] == l_r.filt[i]) begin
        l_nxt.cnt[i] = 4'h0;
      end else if (l_r.cnt[i] == 4'(FILT)) begin
        l_nxt.filt[i] = l_r.sy[i][1];
        l_nxt.cnt[i] = 4'h0;
      end else begin
        l_nxt.cnt[i] = l_r.cnt[i] + 4'h1;
      end
    end
    if (stop_cond) begin
      l_nxt.st = ST_IDLE;
      l_nxt.ack_oe = 1'b0;
    end else if (start_cond) begin
      // A repeated start restarts the address phase from any state.
      l_nxt.st = ST_RECV;
      l_nxt.bitcnt = 4'h0;
      l_nxt.byte_idx = 2'd0;
      l_nxt.ack_oe = 1'b0;
    end else begin
      case (l_r.st)
        ST_RECV: begin
          if (scl_rise && l_r.bitcnt < 4'(BYTE_BITS)) begin
            l_nxt.shreg = {l_r.shreg[6:0], sda_f};
            l_nxt.bitcnt = l_r.bitcnt + 4'h1;
          end else if (scl_fall && l_r.bitcnt == 4'(BYTE_BITS)) begin
            l_nxt.st = ST_ACK;
            l_nxt.ack_oe = 1'b1;
            case (l_r.byte_idx)
              2'd0: begin
                if (!addr_hit) begin
                  l_nxt.st = ST_SKIP;
                  l_nxt.ack_oe = 1'b0;
                end
              end
              2'd1: begin
                l_nxt.ptr = l_r.shreg;
              end
              default: begin
                // Pointer advances so a burst fills successive registers.
                if (l_r.ptr < 8'(NUM_REGS)) begin
                  l_nxt.cfg[l_r.ptr[2:0]] = l_r.shreg;
                  l_nxt.tgl = ~l_r.tgl;
                end
                l_nxt.ptr = l_r.ptr + 8'h01;
              end
            endcase
            if (l_r.byte_idx != 2'd2) begin
              l_nxt.byte_idx = l_r.byte_idx + 2'd1;
            end
          end
        end
        ST_ACK: begin
          // Low is held through the whole high phase of the ninth pulse.
          if (scl_fall) begin
            l_nxt.ack_oe = 1'b0;
            l_nxt.bitcnt = 4'h0;
            l_nxt.st = ST_RECV;
          end
        end
        ST_IDLE: begin
          l_nxt.ack_oe = 1'b0;
        end
        ST_SKIP: begin
          l_nxt.ack_oe = 1'b0;
        end
        default: begin
          l_nxt.st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // The link settings are stable for many core cycles after a toggle.
  always_comb begin
    c_nxt = c_r;
    c_nxt.tgl_sy = {c_r.tgl_sy[0], l_r.tgl};
    c_nxt.tgl_p = c_r.tgl_sy[1];
    c_nxt.upd = 1'b0;
    if (c_r.tgl_sy[1] != c_r.tgl_p) begin
      c_nxt.upd = 1'b1;
      for (int k = 0; k < NUM_OUT; k++) begin
        c_nxt.route[k] = l_r.cfg[REG_ROUTE_BASE + k / 2]
          [(k % 2) * SEL_W +: SEL_W];
        // Code zero powers down; codes past the last input leave it idle.
        c_nxt.amp_on[k] = c_nxt.route[k] != SEL_OFF;
        c_nxt.idle[k] = c_nxt.route[k] > SEL_MAX;
      end
      c_nxt.clamp = l_r.cfg[REG_CLAMP];
      c_nxt.gain = l_r.cfg[REG_GAIN][NUM_OUT-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign route_sel_r = c_r.route;
  assign amp_on_r = c_r.amp_on;
  assign idle_in_r = c_r.idle;
  assign clamp_mode_r = c_r.clamp;
  assign gain_0db_r = c_r.gain;
  assign cfg_update_r = c_r.upd;
endmodule

//--- core/vmic_host.sv
// Purpose: Bus master that writes one pointer and one data byte.
// Assumes: SCL is divided from core_clk in four quarter periods per bit.
// Notes: A missing acknowledge ends the transfer with a stop.
`timescale 1ns/1ps
module vmic_host
  import vmic_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  input wire logic core_clk, // Core clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  vmic_if.host bus, // Two-wire bus.
  input wire logic wr_valid, // Request a write transfer.
  input wire logic [7:0] wr_addr_byte, // Address byte with R/W bit.
  input wire logic [7:0] wr_ptr, // Register pointer byte.
  input wire logic [7:0] wr_data, // Data byte.
  output logic wr_ready_r, // Idle and able to take a request.
  output logic wr_done_r, // One-cycle pulse at transfer end.
  output logic wr_nack_r // Last transfer saw a missing ack.
);
  if (QTR < 2 || QTR > 65535) begin : g_bad_qtr
    $error("QTR must lie between 2 and 65535");
  end

  typedef enum logic [2:0] {
    H_IDLE,
    H_START,
    H_BIT,
    H_STOP,
    H_GAP
  } vmic_hst_type;

  typedef struct packed {
    vmic_hst_type st;
    logic [15:0] div;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic [7:0] sh;
    logic [15:0] pend;
    logic [1:0] sda_sy;
    logic scl_oe;
    logic sda_oe;
    logic ready;
    logic done;
    logic nack;
  } vmic_hreg_type;

  vmic_hreg_type h_r;
  vmic_hreg_type h_nxt;
  logic tick;

  assign tick = h_r.div == 16'(QTR - 1);
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe = h_r.scl_oe;
  assign bus.host_sda_oe = h_r.sda_oe;

  always_comb begin
    h_nxt = h_r;
    h_nxt.sda_sy = {h_r.sda_sy[0], bus.sda};
    h_nxt.done = 1'b0;
    h_nxt.div = tick ? 16'h0000 : h_r.div + 16'h0001;
    case (h_r.st)
      H_IDLE: begin
        h_nxt.scl_oe = 1'b0;
        h_nxt.sda_oe = 1'b0;
        h_nxt.ready = 1'b1;
        if (h_r.ready && wr_valid) begin
          h_nxt.ready = 1'b0;
          h_nxt.nack = 1'b0;
          h_nxt.sh = wr_addr_byte;
          h_nxt.pend = {wr_ptr, wr_data};
          h_nxt.div = 16'h0000;
          h_nxt.q = 2'd0;
          h_nxt.st = H_START;
        end
      end
      H_START: begin
        if (tick) begin
          h_nxt.q = h_r.q + 2'd1;
          if (h_r.q == 2'd0) begin
            h_nxt.sda_oe = 1'b1;
          end
          if (h_r.q == 2'd3) begin
            h_nxt.scl_oe = 1'b1;
            h_nxt.bitn = 4'h0;
            h_nxt.byten = 2'd0;
            h_nxt.st = H_BIT;
          end
        end
      end
      H_BIT: begin
        if (tick) begin
          h_nxt.q = h_r.q + 2'd1;
          case (h_r.q)
            2'd0: begin
              // Data changes only while SCL is low; ack slot is released.
              h_nxt.sda_oe = (h_r.bitn < 4'(BYTE_BITS))
                ? ~h_r.sh[7] : 1'b0;
            end
            2'd1: begin
              h_nxt.scl_oe = 1'b0;
            end
            2'd2: begin
              if (h_r.bitn == 4'(BYTE_BITS)) begin
                h_nxt.nack = h_r.sda_sy[1];
              end
            end
            default: begin
              h_nxt.scl_oe = 1'b1;
              if (h_r.bitn < 4'(BYTE_BITS)) begin
                h_nxt.sh = {h_r.sh[6:0], 1'b0};
                h_nxt.bitn = h_r.bitn + 4'h1;
              end else begin
                h_nxt.bitn = 4'h0;
                if (h_r.nack || h_r.byten == 2'd2) begin
                  h_nxt.st = H_STOP;
                end else begin
                  h_nxt.byten = h_r.byten + 2'd1;
                  h_nxt.sh = h_r.pend[15:8];
                  h_nxt.pend = {h_r.pend[7:0], 8'h00};
                end
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          h_nxt.q = h_r.q + 2'd1;
          if (h_r.q == 2'd0) begin
            h_nxt.sda_oe = 1'b1;
          end
          if (h_r.q == 2'd1) begin
            h_nxt.scl_oe = 1'b0;
          end
          if (h_r.q == 2'd3) begin
            h_nxt.sda_oe = 1'b0;
            h_nxt.st = H_GAP;
          end
        end
      end
      H_GAP: begin
        // Bus free time before another start may follow.
        if (tick) begin
          h_nxt.q = h_r.q + 2'd1;
          if (h_r.q == 2'd3) begin
            h_nxt.done = 1'b1;
            h_nxt.st = H_IDLE;
          end
        end
      end
      default: begin
        h_nxt.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign wr_ready_r = h_r.ready;
  assign wr_done_r = h_r.done;
  assign wr_nack_r = h_r.nack;
endmodule

//--- dv/test_video_matrix_i2c_config.sv
// Purpose: Host writes across the link into the device settings.
// Assumes: Shortened counts FILT 2 and QTR 32.
// Notes: Expected settings are worked out from the written bytes.
`timescale 1ns/1ps
module test_video_matrix_i2c_config;
  import vmic_pkg::*;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic addr_select_lo_pin = 1'b0;
  logic addr_select_hi_pin = 1'b0;
  logic wr_valid = 1'b0;
  logic [7:0] wr_addr_byte = 8'h00;
  logic [7:0] wr_ptr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [23:0] route_sel_r;
  logic [5:0] amp_on_r;
  logic [5:0] idle_in_r;
  logic [7:0] clamp_mode_r;
  logic [5:0] gain_0db_r;
  logic cfg_update_r;
  logic wr_ready_r;
  logic wr_done_r;
  logic wr_nack_r;
  int error_cnt = 0;
  int n_checks = 0;
  int upd_cnt = 0;
  vmic_if bus_if();
  always #2.5 core_clk = ~core_clk;
  always #3 link_clk = ~link_clk;
  vmic_dev #(.FILT(2)) vmic_dev_inst (
    .link_clk(link_clk), .core_clk(core_clk), .rst_n(rst_n),
    .addr_select_lo_pin(addr_select_lo_pin),
    .addr_select_hi_pin(addr_select_hi_pin), .bus(bus_if),
    .route_sel_r(route_sel_r), .amp_on_r(amp_on_r),
    .idle_in_r(idle_in_r), .clamp_mode_r(clamp_mode_r),
    .gain_0db_r(gain_0db_r), .cfg_update_r(cfg_update_r));
  vmic_host #(.QTR(32)) vmic_host_inst (
    .core_clk(core_clk), .rst_n(rst_n), .bus(bus_if),
    .wr_valid(wr_valid), .wr_addr_byte(wr_addr_byte), .wr_ptr(wr_ptr),
    .wr_data(wr_data), .wr_ready_r(wr_ready_r), .wr_done_r(wr_done_r),
    .wr_nack_r(wr_nack_r));
  vmic_properties vmic_properties_inst (
    .link_clk(link_clk), .rst_n(rst_n), .scl(bus_if.scl),
    .sda(bus_if.sda), .host_sda_oe(bus_if.host_sda_oe),
    .dev_sda_oe(bus_if.dev_sda_oe));
  always @(posedge core_clk) begin
    if (cfg_update_r === 1'b1) upd_cnt++;
  end
  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cfg_chk(input logic [23:0] r, input logic [5:0] on,
                         input logic [5:0] idl, input logic [7:0] cl,
                         input logic [5:0] g);
    chk("route", r, route_sel_r);
    chk("amp_on", 24'(on), 24'(amp_on_r));
    chk("idle_in", 24'(idl), 24'(idle_in_r));
    chk("clamp", 24'(cl), 24'(clamp_mode_r));
    chk("gain", 24'(g), 24'(gain_0db_r));
  endtask
  // Holds the request from one edge to the next, then waits for done.
  task automatic wr(input logic [7:0] a, input logic [7:0] p,
                    input logic [7:0] d);
    int n;
    n = 0;
    while (wr_ready_r !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 100) begin
      error_cnt++;
      $display("BAD ready expected 1 seen timeout");
    end
    @(posedge core_clk);
    wr_valid <= 1'b1;
    wr_addr_byte <= a;
    wr_ptr <= p;
    wr_data <= d;
    @(posedge core_clk);
    wr_valid <= 1'b0;
    n = 0;
    while (wr_done_r !== 1'b1 && n < 6000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 6000) begin
      error_cnt++;
      $display("BAD done expected 1 seen timeout");
    end
    repeat (20) @(negedge core_clk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    int i;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (40) @(negedge core_clk);
    cfg_chk(24'h0, 6'h0, 6'h0, 8'h0, 6'h0);
    $display("test reset done");
    wr(8'h06, 8'h00, 8'h21);
    wr(8'h06, 8'h01, 8'h93);
    wr(8'h06, 8'h02, 8'h08);
    chk("nack", 24'h0, 24'(wr_nack_r));
    cfg_chk(24'h089321, 6'h1f, 6'h08, 8'h0, 6'h0);
    wr(8'h06, 8'h03, 8'ha5);
    cfg_chk(24'h089321, 6'h1f, 6'h08, 8'ha5, 6'h0);
    $display("test routing and clamp done");
    wr(8'h06, 8'h07, 8'hff);
    chk("nack", 24'h0, 24'(wr_nack_r));
    wr(8'h08, 8'h03, 8'h00);
    chk("nack", 24'h1, 24'(wr_nack_r));
    wr(8'h07, 8'h03, 8'h00);
    chk("nack", 24'h1, 24'(wr_nack_r));
    wr(8'h46, 8'h03, 8'h00);
    chk("nack", 24'h1, 24'(wr_nack_r));
    cfg_chk(24'h089321, 6'h1f, 6'h08, 8'ha5, 6'h0);
    $display("test refused writes done");
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk);
      addr_select_lo_pin <= i[0];
      addr_select_hi_pin <= i[1];
      repeat (20) @(negedge core_clk);
      wr({i[1:0], 6'h06}, 8'h04, 8'hc0 + 8'(9 * (i + 1)));
      chk("nack", 24'h0, 24'(wr_nack_r));
      chk("gain", 24'(9 * (i + 1)), 24'(gain_0db_r));
    end
    $display("test address straps and gain done");
    wr(8'hc6, 8'h03, 8'h00);
    cfg_chk(24'h089321, 6'h1f, 6'h08, 8'h00, 6'h24);
    $display("test bias for all inputs done");
    chk("updates", 24'h9, 24'(upd_cnt));
    finish_test();
  end
  initial begin
    repeat (80000) @(posedge core_clk);
    error_cnt++;
    $display("BAD run expected end seen watchdog");
    finish_test();
  end
endmodule

//--- dv/vmic_properties.sv
// Purpose: Bus-level checks on the two-wire link between host and device.
// Assumes: Lines are resolved levels, sampled on link_clk.
// Notes: The bit count runs 1 to 9 per byte and clears on a start.
`timescale 1ns/1ps
module vmic_properties (
  input wire logic link_clk, // Sampling clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic scl, // Resolved clock line.
  input wire logic sda, // Resolved data line.
  input wire logic host_sda_oe, // Host pulls data low.
  input wire logic dev_sda_oe // Device pulls data low.
);
  typedef struct packed {
    logic scl;
    logic sda;
    logic busy;
    logic [3:0] bits;
  } vmic_chk_type;
  vmic_chk_type st_r;
  vmic_chk_type st_nxt;
  logic start_now;
  logic stop_now;
  assign start_now = st_r.scl && scl && st_r.sda && !sda;
  assign stop_now = st_r.scl && scl && !st_r.sda && sda;
  always_comb begin
    st_nxt = st_r;
    st_nxt.scl = scl;
    st_nxt.sda = sda;
    if (start_now) begin
      st_nxt.busy = 1'b1;
      st_nxt.bits = 4'h0;
    end else if (stop_now) begin
      st_nxt.busy = 1'b0;
    end else if (!st_r.scl && scl) begin
      st_nxt.bits = (st_r.bits == 4'h9) ? 4'h1 : st_r.bits + 4'h1;
    end
  end
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{scl: 1'b1, sda: 1'b1, busy: 1'b0, bits: 4'h0};
    end else begin
      st_r <= st_nxt;
    end
  end
  default clocking @(posedge link_clk); endclocking
  default disable iff (!rst_n);
  idle_lines_a: assert property (
    !st_r.busy |-> scl && (sda || start_now))
    else $error("bus not idle high outside a transfer");
  idle_dev_a: assert property (
    !st_r.busy |-> !dev_sda_oe)
    else $error("device pulls data outside a transfer");
  ack_slot_a: assert property (
    $rose(dev_sda_oe) |-> st_r.bits == 4'h8 && !scl)
    else $error("device drives data outside the ack slot");
  ack_hold_a: assert property (
    $rose(scl) && dev_sda_oe |-> (dev_sda_oe && !sda)[*8])
    else $error("ack not held through clock high");
  ack_release_a: assert property (
    $fell(scl) && dev_sda_oe |-> ##[1:20] !dev_sda_oe)
    else $error("ack not released after the ack slot");
  data_steady_a: assert property (
    $changed(host_sda_oe) && scl && st_r.scl && st_r.busy |-> ##1 !st_r.busy)
    else $error("data changed while clock high");
  start_hold_a: assert property (
    start_now && !st_r.busy |-> scl[*8])
    else $error("clock fell too soon after start");
  stop_idle_a: assert property (
    stop_now |-> (scl && sda)[*8])
    else $error("bus not idle after stop");
  clock_low_a: assert property (
    $fell(scl) |-> (!scl)[*8])
    else $error("clock low phase too short");
endmodule

//--- shared/vmic_if.sv
// Purpose: Open-drain two-wire bus joining the host and the device.
// Assumes: External pull-ups; a line is low when any enabled driver pulls it.
// Notes: Output values are kept for completeness; drivers only pull low.
`timescale 1ns/1ps
interface vmic_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND of all drivers with a pull-up.
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (
    input scl,
    input sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
  modport dev (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe
  );
endinterface

//--- shared/vmic_pkg.sv
// Purpose: Shared constants for the video matrix two-wire configuration port.
// Assumes: Core clock 200 MHz, bus sampling clock with 6 ns period.
// Notes: Register pointers 0x00 to 0x04; all others are write-ignored.
package vmic_pkg;
  localparam int CORE_MHZ = 200;
  localparam int SCL_KHZ = 100;
  localparam int QTR_CYC = CORE_MHZ * 1000 / (SCL_KHZ * 4);
  localparam int SPIKE_NS = 50;
  localparam int LINK_PERIOD_PS = 6000;
  localparam int FILT_CYC = SPIKE_NS * 1000 / LINK_PERIOD_PS;
  localparam logic [7:0] ADDR_BASE = 8'h06;
  localparam int RW_BIT = 0;
  localparam int NUM_IN = 8;
  localparam int NUM_OUT = 6;
  localparam int SEL_W = 4;
  localparam int BYTE_BITS = 8;
  localparam int REG_ROUTE_BASE = 'h00;
  localparam int REG_CLAMP = 'h03;
  localparam int REG_GAIN = 'h04;
  localparam int NUM_REGS = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [3:0] SEL_OFF = 4'h0;
  localparam logic [3:0] SEL_MAX = 4'h8;
endpackage
